// *** acrt_core.sv ***
// result fifo and conversion/readout sequencer with its ahb-lite registers
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// result fifo
module acrt_fifo
   import acrt_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } acrt_fifo_t;
   acrt_fifo_t s;
   acrt_fifo_t n;
   logic       push;
   logic       pop;

   assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s.cnt != '0);
   assign out_data  = s.mem[s.rp];
   assign level     = s.cnt;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      n = s;
      if (push) begin
         n.mem[s.wp] = in_data;
         n.wp        = s.wp + 1'b1;
      end
      if (pop) begin
         n.rp = s.rp + 1'b1;
      end
      n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule : acrt_fifo

// ==========================================
// conversion and readout sequencer
module acrt_core
   import acrt_pkg::*;
(
   // clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // conversion control pins
   input  wire logic              convert_start_n,
   input  wire logic              fast_sel,
   input  wire logic              lowpwr_sel,
   input  wire logic [1:0]        serial_clock_divider,
   output logic                   busy,
   // converter core result
   input  wire logic [RES_W-1:0]  conv_data,
   // parallel port
   input  wire logic              cs_n,
   input  wire logic              rd_n,
   output logic [RES_W-1:0]       par_data,
   output logic                   par_oe_n,
   // serial port
   input  wire logic              ext_sclk,
   output acrt_ser_t              ser_out,
   output acrt_ser_t              ser_oe_n
);
   typedef struct packed {
      logic [2:0]       cv;
      logic [1:0]       cs;
      logic [1:0]       rd;
      logic [2:0]       sck;
      logic [3:0]       md;
      logic [3:0]       dv;
      acrt_state_t      st;
      logic [7:0]       cnt;
      logic [5:0]       scnt;
      logic             busy;
      acrt_speed_t      speed;
      logic [1:0]       div;
      acrt_rmode_t      rmode;
      acrt_rmode_t      ctrl;
      logic [RES_W-1:0] result;
      logic [RES_W-1:0] pdata;
      logic [RES_W-1:0] shreg;
      logic             sh_on;
      logic             sh_end;
      logic [3:0]       hc;
      logic [4:0]       bits;
      logic [1:0]       endc;
      acrt_ser_t        ser;
      acrt_ser_t        ser_oe_n;
      logic             par_oe_n;
      logic             a_wr;
      logic [7:0]       a_addr;
      logic [31:0]      hrdata;
   } acrt_core_t;

   function automatic acrt_core_t rst_state();
      acrt_core_t r;
      r          = '0;
      r.cv       = '1;
      r.cs       = '1;
      r.rd       = '1;
      r.ctrl     = CTRL_RST;
      r.ser_oe_n = '1;
      r.par_oe_n = 1'b1;
      return r;
   endfunction : rst_state

   function automatic logic [3:0] half_cyc(input logic [1:0] d);
      int ns;
      ns = (d == 2'h0) ? SCLK_NS_0 : (d == 2'h1) ? SCLK_NS_1 : (d == 2'h2) ? SCLK_NS_2 : SCLK_NS_3;
      return 4'((ns + 2 * CLK_NS - 1) / (2 * CLK_NS));
   endfunction : half_cyc

   function automatic int conv_ns(input acrt_speed_t sp);
      return (sp == SPD_FAST) ? CONV_NS_FAST : (sp == SPD_LOWPWR) ? CONV_NS_LOWPWR : CONV_NS_NORMAL;
   endfunction : conv_ns

   function automatic int sync_ns(input acrt_speed_t sp);
      return (sp == SPD_FAST) ? SYNC_NS_FAST : (sp == SPD_LOWPWR) ? SYNC_NS_LOWPWR : SYNC_NS_NORMAL;
   endfunction : sync_ns

   acrt_core_t       s;
   acrt_core_t       n;
   acrt_speed_t      spd;
   logic             start_go;
   logic             slave_edge;
   logic             take;
   logic             pop;
   logic             push;
   logic             sh_go;
   logic [RES_W-1:0] sh_word;
   logic             master;
   logic             f_ready;
   logic             f_valid;
   logic [RES_W-1:0] f_data;
   logic [5:0]       f_level;
   acrt_status_t     stat;

   acrt_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (push),
      .in_ready  (f_ready),
      .in_data   (conv_data),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_data),
      .level     (f_level)
   );

   assign spd        = (s.md[3] && !s.md[2]) ? SPD_FAST : s.md[2] ? SPD_LOWPWR : SPD_NORMAL;
   assign start_go   = s.cv[2] && !s.cv[1] && (s.st == ST_IDLE) && f_ready;
   assign slave_edge = s.sck[1] && !s.sck[2];
   assign take       = hsel && htrans[1] && hready;
   assign pop        = take && !hwrite && (haddr[7:0] == REG_DATA);
   assign master     = (s.ctrl == RD_MASTER_DURING) || (s.ctrl == RD_MASTER_AFTER);
   assign stat       = '{rsvd: '0, fifo_full: !f_ready, fifo_level: f_level, shifting: s.sh_on,
                         state: s.st, speed: s.speed, busy: s.busy};

   always_comb begin
      n       = s;
      push    = 1'b0;
      sh_go   = 1'b0;
      sh_word = s.result;
      n.cv    = {s.cv[1:0], convert_start_n};
      n.cs    = {s.cs[0], cs_n};
      n.rd    = {s.rd[0], rd_n};
      n.sck   = {s.sck[1:0], ext_sclk};
      n.md    = {s.md[1:0], fast_sel, lowpwr_sel};
      n.dv    = {s.dv[1:0], serial_clock_divider};
      // ==========================================
      // conversion sequence
      case (s.st)
         ST_IDLE: begin
            if (start_go) begin
               n.busy  = 1'b1;
               n.speed = spd;
               n.div   = s.dv[3:2];
               n.rmode = s.ctrl;
               n.cnt   = 8'(conv_ns(spd) / CLK_NS - START_LAT - TAIL_CYC);
               n.scnt  = 6'(sync_ns(spd) / CLK_NS);
               n.st    = ST_CONV;
            end
         end
         ST_CONV: begin
            if (s.rmode == RD_MASTER_DURING && s.scnt != '0) begin
               n.scnt = s.scnt - 1'b1;
               sh_go  = (s.scnt == 6'h01);
            end
            if (s.cnt == 8'h01) begin
               push     = 1'b1;
               n.result = conv_data;
               if (s.rmode == RD_PARALLEL) begin
                  n.pdata = conv_data;
               end
               if (s.rmode == RD_SLAVE) begin
                  n.shreg   = conv_data;
                  n.ser.sdo = conv_data[RES_W-1];
               end
               if (s.rmode == RD_MASTER_AFTER) begin
                  sh_go   = 1'b1;
                  sh_word = conv_data;
                  n.st    = ST_SHIFT;
               end else begin
                  n.cnt = 8'(TAIL_CYC);
                  n.st  = ST_TAIL;
               end
            end else begin
               n.cnt = s.cnt - 1'b1;
            end
         end
         ST_SHIFT: begin
            if (!s.sh_on) begin
               n.cnt = 8'(SYNC_BUSY_CYC - 1);
               n.st  = ST_TAIL;
            end
         end
         ST_TAIL: begin
            if (s.cnt == 8'h01) begin
               n.busy = 1'b0;
               n.st   = ST_IDLE;
            end else begin
               n.cnt = s.cnt - 1'b1;
            end
         end
         default: n.st = ST_IDLE;
      endcase
      // ==========================================
      // master serial shifter
      if (sh_go) begin
         n.sh_on    = 1'b1;
         n.sh_end   = 1'b0;
         n.ser.sync = 1'b1;
         n.ser.sclk = 1'b0;
         n.shreg    = sh_word;
         n.ser.sdo  = sh_word[RES_W-1];
         n.bits     = 5'(RES_W);
         n.hc       = half_cyc(s.div);
      end else if (s.sh_on) begin
         if (s.hc != 4'h1) begin
            n.hc = s.hc - 1'b1;
         end else begin
            n.hc = half_cyc(s.div);
            if (!s.sh_end) begin
               n.ser.sclk = !s.ser.sclk;
               if (s.ser.sclk) begin
                  n.shreg   = {s.shreg[RES_W-2:0], 1'b0};
                  n.ser.sdo = s.shreg[RES_W-2];
                  n.bits    = s.bits - 1'b1;
                  if (s.bits == 5'h01) begin
                     n.sh_end = 1'b1;
                     n.endc   = 2'(END_HALVES);
                  end
               end
            end else if (s.endc != '0) begin
               n.endc = s.endc - 1'b1;
            end else begin
               n.ser.sync = 1'b0;
               n.sh_on    = 1'b0;
            end
         end
      end
      // ==========================================
      // slave serial shifter
      if (slave_edge && s.rmode == RD_SLAVE && !s.cs[1]) begin
         n.shreg   = {s.shreg[RES_W-2:0], 1'b0};
         n.ser.sdo = s.shreg[RES_W-2];
      end
      // ==========================================
      // output enables
      n.ser_oe_n.sync = !(master && !s.cs[1]);
      n.ser_oe_n.sclk = !(master && !s.cs[1]);
      n.ser_oe_n.sdo  = !((master || s.ctrl == RD_SLAVE) && !s.cs[1]);
      n.par_oe_n      = !(s.ctrl == RD_PARALLEL && !s.cs[1] && !s.rd[1]);
      // ==========================================
      // register access
      n.a_wr   = take && hwrite;
      n.a_addr = haddr[7:0];
      if (s.a_wr && s.a_addr == REG_CTRL) begin
         n.ctrl = acrt_rmode_t'(hwdata[1:0]);
      end
      if (take) begin
         n.hrdata = '0;
         if (hwrite) begin
            n.hrdata = '0;
         end else if (haddr[7:0] == REG_CTRL) begin
            n.hrdata = {30'h0000_0000, s.ctrl};
         end else if (haddr[7:0] == REG_STATUS) begin
            n.hrdata = stat;
         end else if (haddr[7:0] == REG_DATA && f_valid) begin
            n.hrdata = {16'h0000, f_data};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= rst_state();
      end else begin
         s <= n;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s.hrdata;
   assign busy      = s.busy;
   assign par_data  = s.pdata;
   assign par_oe_n  = s.par_oe_n;
   assign ser_out   = s.ser;
   assign ser_oe_n  = s.ser_oe_n;

   // ==========================================
   // checks
   localparam int CHK_BMAX = CONV_NS_LOWPWR / CLK_NS - START_LAT;
   localparam int CHK_SMAX = SYNC_NS_LOWPWR / CLK_NS + 2;

   sequence seq_conv_tail;
      s.busy [*2] ##1 !s.busy;
   endsequence
   sequence seq_sync_tail;
      s.busy [*3] ##1 !s.busy;
   endsequence

   chk_busy_rise: assert property (@(posedge hclk) disable iff (!hresetn)
      start_go |=> s.busy && s.st == ST_CONV) else $error("busy not raised after start");
   chk_busy_width: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(s.busy) && s.rmode != RD_MASTER_AFTER |-> ##[1:CHK_BMAX] !s.busy)
      else $error("busy held past conversion time");
   chk_data_lead: assert property (@(posedge hclk) disable iff (!hresetn)
      push && s.rmode != RD_MASTER_AFTER |=> seq_conv_tail) else $error("busy fell too soon after result");
   chk_par_drive: assert property (@(posedge hclk) disable iff (!hresetn)
      s.ctrl == RD_PARALLEL && !s.cs[1] && !s.rd[1] |=> !par_oe_n) else $error("parallel bus not driven");
   chk_sync_during: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(s.busy) && s.rmode == RD_MASTER_DURING |-> ##[1:CHK_SMAX] s.ser.sync)
      else $error("frame sync late in read during convert");
   chk_sync_after: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(s.ser.sync) && s.rmode == RD_MASTER_AFTER |-> s.st == ST_SHIFT && $past(s.st) == ST_CONV)
      else $error("frame sync before conversion end");
   chk_busy_after: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(s.ser.sync) && s.st == ST_SHIFT |-> seq_sync_tail) else $error("busy not dropped after sync");
   chk_hiz_cs: assert property (@(posedge hclk) disable iff (!hresetn)
      s.cs[1] |=> ser_oe_n == 3'b111) else $error("serial outputs driven with chip select high");
   chk_slave_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      slave_edge && s.rmode == RD_SLAVE && !s.cs[1] |=> ser_out.sdo == $past(s.shreg[RES_W-2]))
      else $error("slave data not advanced");
   chk_bit_count: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(s.ser.sync) |-> s.bits == 5'h00 && !s.ser.sclk) else $error("frame ended before sixteen bits");
endmodule : acrt_core
`default_nettype wire

// *** acrt_pkg.sv ***
// constants and types for the conversion and readout sequencer
package acrt_pkg;
   // ==========================================
   // timing
   localparam int CLK_NS         = 10;
   localparam int CONV_NS_FAST   = 750;
   localparam int CONV_NS_NORMAL = 1000;
   localparam int CONV_NS_LOWPWR = 1250;
   localparam int SYNC_NS_FAST   = 25;
   localparam int SYNC_NS_NORMAL = 275;
   localparam int SYNC_NS_LOWPWR = 525;
   localparam int SCLK_NS_0      = 25;
   localparam int SCLK_NS_1      = 50;
   localparam int SCLK_NS_2      = 100;
   localparam int SCLK_NS_3      = 200;
   localparam int DATA_LEAD_NS   = 12;
   localparam int SYNC_BUSY_NS   = 25;
   localparam int START_LAT      = 3;
   localparam int TAIL_CYC       = (DATA_LEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_BUSY_CYC  = (SYNC_BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int END_HALVES     = 2;
   localparam int RES_W          = 16;
   localparam int FIFO_DEPTH     = 32;
   // ==========================================
   // register map
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;
   // ==========================================
   // types
   typedef enum logic [1:0] {SPD_NORMAL, SPD_FAST, SPD_LOWPWR} acrt_speed_t;
   typedef enum logic [1:0] {RD_PARALLEL, RD_MASTER_DURING, RD_MASTER_AFTER, RD_SLAVE} acrt_rmode_t;
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_TAIL, ST_SHIFT} acrt_state_t;
   localparam acrt_rmode_t CTRL_RST = RD_PARALLEL;
   typedef struct packed {
      logic sync;
      logic sclk;
      logic sdo;
   } acrt_ser_t;
   typedef struct packed {
      logic [18:0] rsvd;
      logic        fifo_full;
      logic [5:0]  fifo_level;
      logic        shifting;
      acrt_state_t state;
      acrt_speed_t speed;
      logic        busy;
   } acrt_status_t;
endpackage : acrt_pkg

// *** acrt_host.sv ***
// host controller model: conversion starts, parallel reads and slave serial reads
`timescale 1ns/10ps
`default_nettype none
module acrt_host
   import acrt_pkg::*;
(
   // clock
   input  wire logic             hclk,
   // speed pins, shared with the device
   input  wire logic             fast_sel,
   input  wire logic             lowpwr_sel,
   // device outputs
   input  wire logic             par_oe_n,
   input  wire logic [RES_W-1:0] par_data,
   input  wire acrt_ser_t        ser_out,
   // host-driven pins
   output logic                  convert_start_n,
   output logic                  rd_n,
   output logic                  ext_sclk
);
   int cyc  = 0;
   int last = -1000;
   initial begin
      convert_start_n = 1'b1;
      rd_n            = 1'b1;
      ext_sclk        = 1'b0;
   end
   // ==========================================
   // start pulse released after two cycles low
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (!convert_start_n && cyc - last >= 2)
         convert_start_n <= 1'b1;
   end
   // ==========================================
   // two cycles of margin on the spacing; fast-mode starts stay far inside 1 ms
   task automatic start();
      int gap;
      gap = (lowpwr_sel ? 1500 : fast_sel ? 1000 : 1250) / CLK_NS + 2;
      while (cyc - last < gap)
         @(posedge hclk);
      convert_start_n <= 1'b0;
      last = cyc;
   endtask : start
   // ==========================================
   // data is taken only once 50 ns have passed since the request
   task automatic par_read(output logic [RES_W-1:0] v, output int t);
      rd_n <= 1'b0;
      t = 0;
      for (int i = 1; i <= 5; i++) begin
         @(posedge hclk);
         if (t == 0 && par_oe_n === 1'b0)
            t = i;
      end
      // a bus left undriven reads back inverted, so a missing enable cannot pass
      v = (par_oe_n === 1'b0) ? par_data : ~par_data;
      rd_n <= 1'b1;
   endtask : par_read
   // ==========================================
   // 80 ns clock period, clock stands low outside the frame
   task automatic slave_read(output logic [RES_W-1:0] w);
      for (int i = 0; i < RES_W; i++) begin
         repeat (4) @(posedge hclk);
         w = {w[RES_W-2:0], ser_out.sdo};
         ext_sclk <= 1'b1;
         repeat (4) @(posedge hclk);
         ext_sclk <= 1'b0;
      end
   endtask : slave_read
endmodule : acrt_host
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the conversion and readout sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb
   import acrt_pkg::*;
;
   logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cs_n = 1'b0;
   logic             hreadyout, hresp, busy, rd_n, par_oe_n, ext_sclk, convert_start_n;
   logic             fast_sel = 1'b1, lowpwr_sel = 1'b0;
   logic [31:0]      haddr = '0, hwdata = '0, hrdata, rv;
   logic [1:0]       htrans = 2'h0, div = 2'h0;
   logic [2:0]       hsize = 3'h2;
   logic [RES_W-1:0] conv_data = '0, par_data, word, pd, d, prev;
   acrt_ser_t        ser_out, ser_oe_n;
   int               miscompares = 0, num_checks = 0, cyc = 0, seed = 32'ha18c_6ddb;
   int               c_rise, c_fall, s_rise, s_fall, gap, t;
   logic [RES_W-1:0] q[$];
   logic [1:0]       sp[4] = '{2'b10, 2'b00, 2'b01, 2'b11};
   acrt_speed_t      xs[4] = '{SPD_FAST, SPD_NORMAL, SPD_LOWPWR, SPD_LOWPWR};
   int               bmax_ns[4] = '{1500, 2000, 3000, 5250};

   acrt_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .convert_start_n(convert_start_n), .fast_sel(fast_sel),
      .lowpwr_sel(lowpwr_sel), .serial_clock_divider(div), .busy(busy), .conv_data(conv_data),
      .cs_n(cs_n), .rd_n(rd_n), .par_data(par_data), .par_oe_n(par_oe_n), .ext_sclk(ext_sclk),
      .ser_out(ser_out), .ser_oe_n(ser_oe_n));
   acrt_host i_host (.hclk(hclk), .fast_sel(fast_sel), .lowpwr_sel(lowpwr_sel), .par_oe_n(par_oe_n),
      .par_data(par_data), .ser_out(ser_out), .convert_start_n(convert_start_n), .rd_n(rd_n),
      .ext_sclk(ext_sclk));

   always #5 hclk = ~hclk;
   // ==========================================
   // expectations in clock cycles
   function automatic int conv_cyc(input logic [1:0] s);
      return (s == 2'd1 ? CONV_NS_FAST : s == 2'd2 ? CONV_NS_LOWPWR : CONV_NS_NORMAL) / CLK_NS;
   endfunction : conv_cyc
   function automatic int sync_cyc(input logic [1:0] s);
      return (s == 2'd1 ? SYNC_NS_FAST : s == 2'd2 ? SYNC_NS_LOWPWR : SYNC_NS_NORMAL) / CLK_NS;
   endfunction : sync_cyc
   function automatic int sclk_cyc(input logic [1:0] v);
      int ns[4] = '{SCLK_NS_0, SCLK_NS_1, SCLK_NS_2, SCLK_NS_3};
      return (ns[v] + CLK_NS - 1) / CLK_NS;
   endfunction : sclk_cyc
   // ==========================================
   // bus, conversion and closing tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask : ahb
   // starts one conversion and watches busy, frame sync and the serial word
   task automatic convert(input int lim);
      logic ps;
      logic [RES_W-1:0] p1, p2;
      int last;
      c_rise = 0;
      c_fall = 0;
      s_rise = 0;
      s_fall = 0;
      last = 0;
      gap = 999;
      ps = 1'b0;
      p1 = '0;
      p2 = '0;
      d = RES_W'($random(seed));
      @(posedge hclk);
      conv_data <= d;
      i_host.start();
      for (int n = 1; n <= lim && !(c_fall && ser_out.sync === 1'b0); n++) begin
         @(posedge hclk);
         #1;
         if (busy === 1'b1 && !c_rise)
            c_rise = n;
         if (busy === 1'b0 && c_rise && !c_fall) begin
            c_fall = n;
            pd = p2;
         end
         if (ser_out.sync === 1'b1 && !s_rise)
            s_rise = n;
         if (ser_out.sync === 1'b0 && s_rise && !s_fall)
            s_fall = n;
         if (ser_out.sync && ser_out.sclk && !ps) begin
            word = {word[RES_W-2:0], ser_out.sdo};
            if (last)
               gap = (n - last < gap) ? n - last : gap;
            last = n;
         end
         ps = ser_out.sclk;
         p2 = p1;
         p1 = par_data;
      end
   endtask : convert

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         close_out();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      `CHK("busy after reset", 1'b0, busy)
      `CHK("serial enables after reset", 3'b111, ser_oe_n)
      `CHK("hresp", 1'b0, hresp)
      ahb(1'b0, REG_CTRL, 32'h0000_0000);
      `CHK("ctrl reset", 32'h0000_0000, rv)
      ahb(1'b1, REG_CTRL, 32'h0000_0003);
      ahb(1'b0, REG_CTRL, 32'h0000_0000);
      `CHK("ctrl readback", 2'h3, rv[1:0])
      ahb(1'b0, 8'h0c, 32'h0000_0000);
      `CHK("unmapped read", 32'h0000_0000, rv)
      ahb(1'b0, REG_DATA, 32'h0000_0000);
      `CHK("empty data read", 32'h0000_0000, rv)
      for (int k = 0; k < 4; k++) begin
         {fast_sel, lowpwr_sel} <= sp[k];
         ahb(1'b1, REG_CTRL, 32'h0000_0000);
         convert(3000);
         `CHK("busy rise", 1'b1, c_rise inside {[1:3]})
         `CHK("conversion end", 1'b1, c_fall <= conv_cyc(xs[k]))
         `CHK("data before busy low", d, pd)
         i_host.par_read(word, t);
         `CHK("bus access delay", 1'b1, t inside {[1:4]})
         `CHK("parallel data", d, word)
         ahb(1'b0, REG_STATUS, 32'h0000_0000);
         `CHK("speed mode", xs[k], rv[2:1])
         prev = d;
         ahb(1'b1, REG_CTRL, 32'h0000_0001);
         convert(3000);
         `CHK("sync delay", 1'b1, s_rise inside {[sync_cyc(xs[k]):sync_cyc(xs[k]) + 6]})
         `CHK("word during convert", prev, word)
      end
      {fast_sel, lowpwr_sel} <= 2'b10;
      ahb(1'b1, REG_CTRL, 32'h0000_0002);
      for (int v = 0; v < 4; v++) begin
         @(posedge hclk);
         div <= v[1:0];
         repeat (4) @(posedge hclk);
         convert(3000);
         `CHK("word after convert", d, word)
         `CHK("sync start", 1'b1, s_rise inside {[conv_cyc(SPD_FAST) - 2:conv_cyc(SPD_FAST) + 2]})
         `CHK("sclk period", 1'b1, gap >= sclk_cyc(v[1:0]))
         `CHK("busy width", 1'b1, c_fall - c_rise <= bmax_ns[v] / CLK_NS)
         `CHK("sync to busy low", SYNC_BUSY_CYC, c_fall - s_fall)
      end
      @(posedge hclk);
      cs_n <= 1'b1;
      repeat (4) @(posedge hclk);
      #1;
      `CHK("outputs float", 3'b111, ser_oe_n)
      @(posedge hclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge hclk);
      #1;
      `CHK("outputs driven", 1'b0, ser_oe_n.sclk)
      ahb(1'b1, REG_CTRL, 32'h0000_0003);
      convert(3000);
      i_host.slave_read(word);
      `CHK("slave word", d, word)
      ahb(1'b1, REG_CTRL, 32'h0000_0000);
      for (int i = 0; i < 40; i++)
         ahb(1'b0, REG_DATA, 32'h0000_0000);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         convert(3000);
         q.push_back(d);
      end
      convert(40);
      `CHK("start refused when full", 0, c_rise)
      ahb(1'b0, REG_STATUS, 32'h0000_0000);
      `CHK("fifo full flag", 1'b1, rv[12])
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         d = q.pop_front();
         ahb(1'b0, REG_DATA, 32'h0000_0000);
         `CHK("fifo data", {16'h0000, d}, rv)
      end
      ahb(1'b0, REG_DATA, 32'h0000_0000);
      `CHK("drained read", 32'h0000_0000, rv)
      close_out();
   end
endmodule : tb
`default_nettype wire
